// [verif/l2_fwd_engine_properties.sv]
`timescale 1ns/1ns
module l2_fwd_engine_props
(
	input wire        i_clk,
	input wire        i_rst,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_desc_valid,
	input wire [47:0] i_da,
	input wire [47:0] i_sa,
	input wire        i_crc_ok,
	input wire [10:0] i_len,
	input wire [31:0] o_prdata,
	input wire        o_pready,
	input wire        o_pslverr,
	input wire        o_rt_req,
	input wire [9:0]  o_rt_index,
	input wire        o_dec_valid,
	input wire [2:0]  o_port_map,
	input wire        o_drop
);
	reg [9:0] hash;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// one hash kept per descriptor; pipelined descriptors overwrite it a cycle later
	always @(posedge i_clk)
		if (i_desc_valid)
			hash <= i_da[9:0] ^ i_da[19:10] ^ i_da[29:20] ^ i_da[39:30] ^ {2'b00, i_da[47:40]};
	a_route_req_next:
		assert property (i_desc_valid |=> o_rt_req) else $error("routing request missing");
	a_route_index_hash:
		assert property (o_rt_req |-> o_rt_index == hash) else $error("routing index wrong");
	a_decision_two_late:
		assert property (i_desc_valid |-> ##2 o_dec_valid) else $error("decision late");
	a_bad_crc_drop:
		assert property (i_desc_valid && !i_crc_ok |-> ##2 o_drop && o_port_map == 3'b000)
		else $error("bad crc forwarded");
	a_short_frame_drop:
		assert property (i_desc_valid && i_len < 11'd64 |-> ##2 o_drop) else $error("short frame kept");
	a_same_addr_drop:
		assert property (i_desc_valid && i_sa == i_da |-> ##2 o_drop) else $error("sa equal da kept");
	a_drop_no_ports:
		assert property (o_dec_valid && o_drop |-> o_port_map == 3'b000) else $error("dropped frame sent");
	a_apb_one_wait:
		assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("apb answer late");
	a_ready_single:
		assert property (o_pready |=> !o_pready) else $error("pready too long");
	a_error_no_data:
		assert property (o_pslverr |-> o_pready && o_prdata == 32'h0) else $error("error with data");
endmodule

// [verif/rt_partner.sv]
`timescale 1ns/1ns
module rt_partner
#(
	parameter [9:0] HIT_IDX = 10'h122,
	parameter [2:0] HIT_MAP = 3'b011
)
(
	input  wire       i_clk,
	input  wire       i_req,
	input  wire [9:0] i_index,
	output wire       o_hit,
	output wire [2:0] o_map
);
	// toggles so an answer outside a request never looks settled
	reg junk = 1'b0;
	always @(posedge i_clk)
		junk <= ~junk;
	// one learned entry at a hashed index
	assign o_hit = i_req ? (i_index == HIT_IDX) : junk;
	assign o_map = i_req ? HIT_MAP : {3{junk}};
endmodule

// [verif/switch_l2_forwarding_vlan_bench.sv]
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module switch_l2_forwarding_vlan_bench;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, dv = 0, crc = 1, tg = 0, ipm = 0;
	logic        bpdu = 0, sniff = 0, same = 0, hit, pready, serr, dec, ins, drop, rtreq, dtag, xd = 0;
	logic [1:0]  src = 0;
	logic [2:0]  pri = 0, rmap, pmap, cmap, umap, opri, xc = 0, xs = 0, xu = 0;
	logic [7:0]  lb = 8'h5a;
	logic [9:0]  ridx;
	logic [10:0] len = 11'd100;
	logic [11:0] paddr = 0, vid = 0, ovid;
	logic [31:0] pwdata = 0, prdata, ip = 0, rnd = 32'h7fc4;
	logic [47:0] da = 0, sa = 0, xsa = 0;
	logic [4:0]  q[$];
	logic [32:0] rq[$];
	logic [4:0]  ed;
	logic [32:0] er;
	logic [21:0] xq[$];
	logic [21:0] xe;
	int          miscompares, samples_checked;

	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task stop_test;
		if (miscompares == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task rd(input logic [11:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	// expected word is {insert_src, drop, port_map}
	task send(input logic [4:0] e, input logic [1:0] s, input logic [47:0] d);
		q.push_back(e);
		rnd = nx(rnd);
		src <= s;
		da <= d;
		sa <= same ? d : (xsa != 48'h0 ? xsa : {16'h0200, rnd});
		sniff <= rnd[3];
		pri <= rnd[2:0];
		dv <= 1'b1;
		@(posedge clk);
		// {copy, untag, vid, pri, double tag}; untagged frames take the port defaults
		xq.push_back({xc | (sniff ? xs : 3'b000), xu, (tg && vid != 12'h000) ? vid : 12'h001, tg ? pri : 3'b000, xd});
		dv <= 1'b0;
		crc <= 1'b1;
		len <= 11'd100;
		same = 1'b0;
		repeat (3) @(posedge clk);
	endtask

	l2_fwd_engine DUT
	(
		.i_clk        (clk),
		.i_rst        (rst),
		.i_psel       (psel),
		.i_penable    (penable),
		.i_pwrite     (pwrite),
		.i_paddr      (paddr),
		.i_pwdata     (pwdata),
		.o_prdata     (prdata),
		.o_pready     (pready),
		.o_pslverr    (serr),
		.i_desc_valid (dv),
		.i_src_port   (src),
		.i_da         (da),
		.i_sa         (sa),
		.i_crc_ok     (crc),
		.i_len        (len),
		.i_tagged     (tg),
		.i_tag_pri    (pri),
		.i_tag_vid    (vid),
		.i_ip_mcast   (ipm),
		.i_dst_ip     (ip),
		.i_bpdu       (bpdu),
		.i_sniff_hit  (sniff),
		.i_last_byte  (lb),
		.i_rt_hit     (hit),
		.i_rt_map     (rmap),
		.o_rt_req     (rtreq),
		.o_rt_index   (ridx),
		.o_dec_valid  (dec),
		.o_port_map   (pmap),
		.o_copy_map   (cmap),
		.o_untag_map  (umap),
		.o_vid        (ovid),
		.o_pri        (opri),
		.o_insert_src (ins),
		.o_drop       (drop),
		.o_double_tag (dtag)
	);

	rt_partner far
	(
		.i_clk   (clk),
		.i_req   (rtreq),
		.i_index (ridx),
		.o_hit   (hit),
		.o_map   (rmap)
	);

	initial
	begin
		forever #10 clk = ~clk;
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		stop_test;
	end

	always @(posedge clk)
	begin
		if (dec === 1'b1)
		begin
			ed = q.size() ? q.pop_front() : 5'bx;
			`CHK("decision", ed, {ins, drop, pmap})
			xe = xq.size() ? xq.pop_front() : 22'bx;
			`CHK("decision fields", xe, {cmap, umap, ovid, opri, dtag})
		end
		if (pready === 1'b1 && pwrite === 1'b0)
		begin
			er = rq.size() ? rq.pop_front() : 33'bx;
			`CHK("read", er, {serr, prdata})
		end
	end

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(12'h000, {1'b0, 32'h000005f2});
		rd(12'h004, 33'h0);
		rd(12'hffc, {1'b1, 32'h0});
		apb(1'b1, 12'h040, 32'h00040153);
		rd(12'h040, {1'b0, 32'h00040153});
		send(5'b00110, 2'b00, 48'h0200);
		crc <= 1'b0;
		send(5'b01000, 2'b00, 48'h0200);
		len <= 11'd63;
		send(5'b01000, 2'b00, 48'h0200);
		len <= 11'd64;
		send(5'b00110, 2'b00, 48'h0200);
		len <= 11'd1522;
		send(5'b00110, 2'b00, 48'h0200);
		len <= 11'd1523;
		send(5'b01000, 2'b00, 48'h0200);
		same = 1'b1;
		send(5'b01000, 2'b01, 48'h0200);
		send(5'b00001, 2'b01, 48'h0122);
		apb(1'b1, 12'h0c0, 32'h02e789ab);
		send(5'b00110, 2'b00, 48'hab8967452301);
		send(5'b00001, 2'b01, 48'hab8967452301);
		send(5'b00010, 2'b00, 48'hac8967452301);
		send(5'b00110, 2'b00, 48'h0200);
		apb(1'b1, 12'h0c0, 32'h0);
		apb(1'b1, 12'h004, 32'h00000040);
		apb(1'b1, 12'h080, 32'ha0000001);
		ipm <= 1'b1;
		ip <= 32'he0000001;
		send(5'b00111, 2'b01, 48'h0001);
		ip <= 32'hf0000001;
		send(5'b00101, 2'b01, 48'h0001);
		ipm <= 1'b0;
		apb(1'b1, 12'h004, 32'h00000020);
		apb(1'b1, 12'h008, 32'h00007ffd);
		bpdu <= 1'b1;
		send(5'b00100, 2'b00, 48'h0200);
		bpdu <= 1'b0;
		send(5'b01000, 2'b00, 48'h0200);
		apb(1'b1, 12'h008, 32'h00007fff);
		// port groups: host port shares both groups
		apb(1'b1, 12'h004, 32'h00100000);
		apb(1'b1, 12'h008, 32'h00000d7f);
		send(5'b00100, 2'b00, 48'hffffffffffff);
		send(5'b00100, 2'b01, 48'hffffffffffff);
		send(5'b00011, 2'b10, 48'hffffffffffff);
		apb(1'b1, 12'h004, 32'h00000200);
		send(5'b01000, 2'b00, 48'h0200);
		xsa = 48'h020000001234;
		apb(1'b1, 12'h100, 32'h00001234);
		apb(1'b1, 12'h104, 32'h00010200);
		send(5'b00110, 2'b00, 48'h0200);
		xsa = 48'h0;
		apb(1'b1, 12'h004, 32'h00400000);
		tg <= 1'b1;
		vid <= 12'h005;
		// vid 5 keeps its tag only on port 1
		xu = 3'b101;
		send(5'b00010, 2'b00, 48'h0200);
		tg <= 1'b0;
		xu = 3'b111;
		send(5'b00000, 2'b00, 48'h0200);
		apb(1'b1, 12'h010, 32'h00010001);
		send(5'b01000, 2'b00, 48'h0200);
		apb(1'b1, 12'h010, 32'h00000001);
		// sniffer copies to host port, mirror to port 1
		xu = 3'b000;
		xc = 3'b010;
		xs = 3'b100;
		apb(1'b1, 12'h004, 32'h00001980);
		send(5'b00110, 2'b00, 48'h0200);
		send(5'b00110, 2'b00, 48'h0200);
		xc = 3'b000;
		xs = 3'b000;
		// software switching with double tag on
		xd = 1'b1;
		apb(1'b1, 12'h004, 32'h00008000);
		apb(1'b1, 12'h000, 32'h100005f2);
		lb <= 8'hfc;
		send(5'b00001, 2'b10, 48'h0200);
		lb <= 8'hfd;
		send(5'b00010, 2'b10, 48'h0200);
		send(5'b10110, 2'b00, 48'h0200);
		repeat (5) @(posedge clk);
		if (q.size() != 0 || rq.size() != 0 || xq.size() != 0)
			miscompares++;
		stop_test;
	end
endmodule

bind l2_fwd_engine l2_fwd_engine_props chk
(
	.i_clk        (i_clk),
	.i_rst        (i_rst),
	.i_psel       (i_psel),
	.i_penable    (i_penable),
	.i_desc_valid (i_desc_valid),
	.i_da         (i_da),
	.i_sa         (i_sa),
	.i_crc_ok     (i_crc_ok),
	.i_len        (i_len),
	.o_prdata     (o_prdata),
	.o_pready     (o_pready),
	.o_pslverr    (o_pslverr),
	.o_rt_req     (o_rt_req),
	.o_rt_index   (o_rt_index),
	.o_dec_valid  (o_dec_valid),
	.o_port_map   (o_port_map),
	.o_drop       (o_drop)
);

// [verilog/l2_fwd_engine.v]
// Operation
// R1: igmp entry holds valid bit 31, port map 30:28, group ip low 28 bits
// R2: multicast ip with top nibble 1110 matching valid igmp entry copies to its ports
// R3: sixteen host filters; if any valid, unmatched multicast to host port dropped
// R4: host delivery needs 23-bit match, multicast da, source enable, valid entry
// R5: filter entry valid 25, from-port1 24, from-port0 23, match 22:0
// R6: decision only after the whole frame sits in packet memory
// R7: forward only good frames: crc ok, 64 to max length, sa differs da
// R8: bit 22 enables tag vlan; frames checked against sixteen vlan entries
// R9: with stp enabled, source port state decides continue or drop
// R10: routing table indexed by a hash of the destination mac
// R11: sniffer hits copied to sniffer port; mirror duplicates to mirror port
// R12: frames failing the eight security mac check are dropped
// R13: gmc bit 28 adds source-port byte to frames from ports 0/1 to host
// R14: software mode forwards host frames by last payload byte low two bits
// R15: bit 20 with port mapping restricts broadcasts to same group
// R16: overlapping groups let shared port hear both, groups stay isolated
// R17: zero tagged vid or untagged uses port default vid, default one
// R18: untagged gets default vid and priority; priority tag keeps priority
// R19: untagged/priority frames dropped on tagged-only port, else vlan membership
// R20: tagged frame from non-member dropped with ingress filter, else membership
// R21: egress untags ports in untagged member set of the vid
// R22: bit 15 of lookup control enables double tagging
// R23: vlan entry holds forward map, tag map, 12-bit vid, valid
// R24: port codes 00 port0, 01 port1, 10 host port
// R25: dropped frames reach no port except sniffer and mirror copies
`timescale 1ns/1ns
`include "l2_fwd_regs.vh"

module l2_fwd_engine
(
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	input  wire        i_desc_valid,
	input  wire [1:0]  i_src_port,
	input  wire [47:0] i_da,
	input  wire [47:0] i_sa,
	input  wire        i_crc_ok,
	input  wire [10:0] i_len,
	input  wire        i_tagged,
	input  wire [2:0]  i_tag_pri,
	input  wire [11:0] i_tag_vid,
	input  wire        i_ip_mcast,
	input  wire [31:0] i_dst_ip,
	input  wire        i_bpdu,
	input  wire        i_sniff_hit,
	input  wire [7:0]  i_last_byte,
	input  wire        i_rt_hit,
	input  wire [2:0]  i_rt_map,
	output reg         o_rt_req,
	output reg  [9:0]  o_rt_index,
	output reg         o_dec_valid,
	output reg  [2:0]  o_port_map,
	output reg  [2:0]  o_copy_map,
	output reg  [2:0]  o_untag_map,
	output reg  [11:0] o_vid,
	output reg  [2:0]  o_pri,
	output reg         o_insert_src,
	output reg         o_drop,
	output reg         o_double_tag
);

////////////////////////////////////////////////////////////////////////////////
// registers and tables

reg [31:0] gmc, lgc, pvm;
reg [17:0] pcfg [0:2];
reg [18:0] vlan [0:15];
reg [31:0] igmp [0:7];
reg [25:0] hmf  [0:15];
reg [47:0] sec  [0:7];
reg        sec_v [0:7];
reg [15:0] fwd_cnt, drop_cnt;
wire acc    = i_psel && i_penable && !o_pready;
wire in_vl  = i_paddr[11:6] == `BASE_VLAN;
wire in_ig  = i_paddr[11:5] == `BASE_IGMP;
wire in_hm  = i_paddr[11:6] == `BASE_HMF;
wire in_sec = i_paddr[11:6] == `BASE_SEC;
wire in_pc  = i_paddr == `OFS_PCFG0 || i_paddr == `OFS_PCFG1 || i_paddr == `OFS_PCFG2;
wire [1:0] pc_idx = i_paddr[3:2];
wire mapped = in_vl || in_ig || in_hm || in_sec || in_pc || i_paddr == `OFS_GMC
	|| i_paddr == `OFS_LGC || i_paddr == `OFS_PVM || i_paddr == `OFS_STAT;
wire wr = i_psel && i_penable && o_pready && i_pwrite && mapped;
integer k, j;

always @(posedge i_clk)
begin
	if (i_rst)
	begin
		gmc <= `GMC_RESET;
		lgc <= `LGC_RESET;
		pvm <= `PVM_RESET;
		for (k = 0; k < 3; k = k + 1)
			pcfg[k] <= `PCFG_RESET;
		for (k = 0; k < 16; k = k + 1)
		begin
			vlan[k] <= 19'h00000;
			hmf[k]  <= 26'h0000000;
		end
		for (k = 0; k < 8; k = k + 1)
		begin
			igmp[k]  <= 32'h00000000;
			sec[k]   <= 48'h000000000000;
			sec_v[k] <= 1'b0;
		end
	end
	else if (wr)
	begin
		if (i_paddr == `OFS_GMC)
			gmc <= i_pwdata;
		if (i_paddr == `OFS_LGC)
			lgc <= i_pwdata;
		if (i_paddr == `OFS_PVM)
			pvm <= {17'h00000, i_pwdata[14:0]};
		if (in_pc)
			pcfg[pc_idx] <= i_pwdata[17:0];
		if (in_vl)
			vlan[i_paddr[5:2]] <= i_pwdata[18:0];
		if (in_ig)
			igmp[i_paddr[4:2]] <= i_pwdata;
		if (in_hm)
			hmf[i_paddr[5:2]] <= i_pwdata[25:0];
		if (in_sec && !i_paddr[2])
			sec[i_paddr[5:3]][31:0] <= i_pwdata;
		if (in_sec && i_paddr[2])
		begin
			sec[i_paddr[5:3]][47:32] <= i_pwdata[15:0];
			sec_v[i_paddr[5:3]] <= i_pwdata[`SEC_VALID];
		end
	end
end

reg [31:0] rdata;
always @*
begin
	rdata = 32'h00000000;
	if (i_paddr == `OFS_GMC)
		rdata = gmc;
	else if (i_paddr == `OFS_LGC)
		rdata = lgc;
	else if (i_paddr == `OFS_PVM)
		rdata = pvm;
	else if (i_paddr == `OFS_STAT)
		rdata = {drop_cnt, fwd_cnt};
	else if (in_pc)
		rdata = {14'h0000, pcfg[pc_idx]};
	else if (in_vl)
		rdata = {13'h0000, vlan[i_paddr[5:2]]};
	else if (in_ig)
		rdata = igmp[i_paddr[4:2]];
	else if (in_hm)
		rdata = {6'h00, hmf[i_paddr[5:2]]};
	else if (in_sec && !i_paddr[2])
		rdata = sec[i_paddr[5:3]][31:0];
	else if (in_sec)
		rdata = {15'h0000, sec_v[i_paddr[5:3]], sec[i_paddr[5:3]][47:32]};
end

// one wait state keeps pready and prdata straight from flops
always @(posedge i_clk)
begin
	if (i_rst)
	begin
		o_pready  <= 1'b0;
		o_pslverr <= 1'b0;
		o_prdata  <= 32'h00000000;
	end
	else
	begin
		o_pready  <= acc;
		o_pslverr <= acc && !mapped;
		o_prdata  <= (acc && !i_pwrite) ? rdata : 32'h00000000;
	end
end

////////////////////////////////////////////////////////////////////////////////
// stage 1: capture descriptor of a fully stored frame

reg        s_vld, s_good, s_tagged, s_ipm, s_bpdu, s_sniff;
reg [1:0]  s_src, s_swb;
reg [2:0]  s_tpri;
reg [11:0] s_tvid;
reg [31:0] s_ip;
reg [47:0] s_da, s_sa;
wire [10:0] max_len = gmc[`GMC_MAXLEN_HI:0];

always @(posedge i_clk)
begin
	if (i_rst)
	begin
		s_vld      <= 1'b0;
		o_rt_req   <= 1'b0;
		o_rt_index <= 10'h000;
	end
	else
	begin
		// R6 store then decide
		s_vld    <= i_desc_valid;
		o_rt_req <= i_desc_valid;
		// R10 hashed routing index
		o_rt_index <= i_da[9:0] ^ i_da[19:10] ^ i_da[29:20] ^ i_da[39:30] ^ {2'b00, i_da[47:40]};
	end
	s_src    <= i_src_port;
	s_da     <= i_da;
	s_sa     <= i_sa;
	// R7 good frame check
	s_good   <= i_crc_ok && i_len >= `MIN_FRAME_LEN && i_len <= max_len && i_sa != i_da;
	s_tagged <= i_tagged;
	s_tpri   <= i_tag_pri;
	s_tvid   <= i_tag_vid;
	s_ipm    <= i_ip_mcast;
	s_ip     <= i_dst_ip;
	s_bpdu   <= i_bpdu;
	s_sniff  <= i_sniff_hit;
	s_swb    <= i_last_byte[1:0];
end

////////////////////////////////////////////////////////////////////////////////
// stage 2: table matches

wire        prio_tag = s_tagged && s_tvid == 12'h000;
wire [17:0] scfg     = pcfg[s_src];
// R17 vid classification
wire [11:0] vid      = (s_tagged && !prio_tag) ? s_tvid : scfg[11:0];
// R18 untagged takes port priority
wire [2:0]  pri      = s_tagged ? s_tpri : scfg[`PCFG_PRI_LO+2:`PCFG_PRI_LO];
wire [2:0]  sbit     = 3'b001 << s_src;
wire [1:0]  st       = pvm[2*s_src+:2];
wire [22:0] da_key   = {s_da[30:24], s_da[39:32], s_da[47:40]};

wire [15:0] vl_m, hm_m, hm_v;
wire [7:0]  ig_m, sec_m;
wire [2:0]  grp_m;

genvar g;
generate
	for (g = 0; g < 16; g = g + 1)
	begin : tab16
		// R23 vlan entry lookup
		assign vl_m[g] = vlan[g][`VL_VALID] && vlan[g][`VL_VID_LO+11:`VL_VID_LO] == vid;
		assign hm_v[g] = hmf[g][`HM_VALID];
		// R4 R5 all four host filter conditions
		assign hm_m[g] = hm_v[g] && s_da[0] && hmf[g][22:0] == da_key
			&& ((s_src == `PORT0 && hmf[g][`HM_FROM0]) || (s_src == `PORT1 && hmf[g][`HM_FROM1]));
	end
	for (g = 0; g < 8; g = g + 1)
	begin : tab8
		// R1 top nibble assumed multicast
		assign ig_m[g]  = igmp[g][`IG_VALID] && igmp[g][27:0] == s_ip[27:0];
		// R12 security mac match
		assign sec_m[g] = sec_v[g] && sec[g] == s_sa;
	end
	for (g = 0; g < 3; g = g + 1)
	begin : grp
		// R16 every group holding the source contributes
		assign grp_m[g] = pvm[`PVM_GRP_LO+3*g+s_src];
	end
endgenerate

reg [2:0] vl_fwd, vl_tag, ig_map, grp_u;

always @*
begin
	vl_fwd = 3'b000;
	vl_tag = 3'b000;
	ig_map = 3'b000;
	grp_u  = 3'b000;
	for (j = 0; j < 16; j = j + 1)
		if (vl_m[j])
		begin
			vl_fwd = vl_fwd | vlan[j][2:0];
			vl_tag = vl_tag | vlan[j][`VL_TAG_LO+2:`VL_TAG_LO];
		end
	for (j = 0; j < 8; j = j + 1)
		if (ig_m[j])
			ig_map = ig_map | igmp[j][`IG_MAP_LO+2:`IG_MAP_LO];
	for (j = 0; j < 3; j = j + 1)
		if (grp_m[j])
			grp_u = grp_u | pvm[`PVM_GRP_LO+3*j+:3];
end

////////////////////////////////////////////////////////////////////////////////
// stage 2: forwarding decision

wire sw_mode = gmc[`GMC_SWMODE];
wire bcast   = &s_da;
reg [2:0] next_map, next_copy;
reg       next_drop;

always @*
begin
	next_drop = !s_good;
	next_copy = 3'b000;
	if (sw_mode && s_src == `PORT_HOST)
	begin
		// R14 software chooses the egress port
		case (s_swb)
			2'b00:   next_map = 3'b001;
			2'b01:   next_map = 3'b010;
			default: next_map = 3'b000;
		endcase
	end
	else
	begin
		// R24 lookup map excludes the source; igmp copies or host bpdus can add it back
		next_map = (bcast || !i_rt_hit) ? ~sbit : (i_rt_map & ~sbit);
		// R15 port-based group restriction
		if (lgc[`LGC_PVLAN_EN])
			next_map = next_map & grp_u;
		// R8 tag vlan membership
		if (lgc[`LGC_VLAN_EN])
		begin
			// R19 untagged or priority frames
			if ((!s_tagged || prio_tag) && scfg[`PCFG_TAGONLY])
				next_drop = 1'b1;
			// R20 ingress filtering
			if (s_tagged && !prio_tag && !vl_fwd[s_src] && scfg[`PCFG_INFILT])
				next_drop = 1'b1;
			next_map = next_map & vl_fwd;
		end
		// R9 port state gate, bpdus go to host unless the port is disabled
		if (lgc[`LGC_STP_EN] && st != `STP_FORWARD)
		begin
			if (s_bpdu && st != `STP_DISABLED)
				next_map = 3'b100;
			else
				next_drop = 1'b1;
		end
		// R3 host multicast filter
		if (|hm_v && s_da[0] && !(|hm_m))
			next_map[2] = 1'b0;
		// R2 igmp snooping copy
		if (lgc[`LGC_IGMP_EN] && s_ipm && s_ip[31:28] == `IG_TOP_NIBBLE)
			next_map = next_map | ig_map;
		// R12 security drop
		if (lgc[`LGC_SEC_EN] && !(|sec_m))
			next_drop = 1'b1;
	end
	// R11 sniffer and mirror copies
	if (s_good && lgc[`LGC_SNIFF_EN] && s_sniff)
		next_copy = next_copy | (3'b001 << lgc[`LGC_SNIFF_LO+:2]);
	if (s_good && lgc[`LGC_MIRR_EN])
		next_copy = next_copy | (3'b001 << lgc[`LGC_MIRR_LO+:2]);
	// R25 dropped frame gets an empty port map; sniffer and mirror copies still apply when s_good is set
	if (next_drop)
		next_map = 3'b000;
end

always @(posedge i_clk)
begin
	if (i_rst)
	begin
		o_dec_valid  <= 1'b0;
		o_port_map   <= 3'b000;
		o_copy_map   <= 3'b000;
		o_untag_map  <= 3'b000;
		o_vid        <= 12'h000;
		o_pri        <= 3'b000;
		o_insert_src <= 1'b0;
		o_drop       <= 1'b0;
		o_double_tag <= 1'b0;
		fwd_cnt      <= 16'h0000;
		drop_cnt     <= 16'h0000;
	end
	else
	begin
		// R22 double tag enable
		o_double_tag <= lgc[`LGC_DTAG_EN];
		o_dec_valid  <= s_vld;
		if (s_vld)
		begin
			o_port_map  <= next_map;
			o_copy_map  <= next_copy;
			// R21 untagged member set
			o_untag_map <= lgc[`LGC_VLAN_EN] ? ~vl_tag : 3'b000;
			o_vid       <= vid;
			o_pri       <= pri;
			o_drop      <= next_drop;
			// R13 source-port byte toward host
			o_insert_src <= sw_mode && s_src != `PORT_HOST && next_map[2];
			if (next_drop)
				drop_cnt <= drop_cnt + 16'h0001;
			else
				fwd_cnt <= fwd_cnt + 16'h0001;
		end
	end
end

endmodule

// [verilog/l2_fwd_regs.vh]
`ifndef L2_FWD_REGS_VH
`define L2_FWD_REGS_VH

// register byte offsets
`define OFS_GMC        12'h000
`define OFS_LGC        12'h004
`define OFS_PVM        12'h008
`define OFS_PCFG0      12'h010
`define OFS_PCFG1      12'h014
`define OFS_PCFG2      12'h018
`define OFS_STAT       12'h020
`define BASE_VLAN      6'h01
`define BASE_IGMP      7'h04
`define BASE_HMF       6'h03
`define BASE_SEC       6'h04

// global_mac_control
`define GMC_MAXLEN_HI  10
`define GMC_SWMODE     28
`define GMC_RESET      32'h000005f2

// lookup_global_control
`define LGC_VLAN_EN    22
`define LGC_PVLAN_EN   20
`define LGC_DTAG_EN    15
`define LGC_STP_EN     5
`define LGC_IGMP_EN    6
`define LGC_SNIFF_EN   7
`define LGC_MIRR_EN    8
`define LGC_SEC_EN     9
`define LGC_SNIFF_LO   10
`define LGC_MIRR_LO    12
`define LGC_RESET      32'h00000000

// port_vlan_mapping: stp states [5:0], groups [14:6]
`define PVM_GRP_LO     6
`define PVM_RESET      32'h00007fff

// per-port config: port_default_vid, priority, tagged only, ingress filter
`define PCFG_PRI_LO    12
`define PCFG_TAGONLY   16
`define PCFG_INFILT    17
`define PCFG_RESET     18'h00001

// table entry fields
`define VL_VALID       18
`define VL_VID_LO      6
`define VL_TAG_LO      3
`define IG_VALID       31
`define IG_MAP_LO      28
`define IG_TOP_NIBBLE  4'he
`define HM_VALID       25
`define HM_FROM1       24
`define HM_FROM0       23
`define SEC_VALID      16

// port numbers and stp states
`define PORT0          2'b00
`define PORT1          2'b01
`define PORT_HOST      2'b10
`define STP_DISABLED   2'b00
`define STP_FORWARD    2'b11

`define MIN_FRAME_LEN  11'd64

`endif
